// [strap_cfg_pkg.sv]
// constants for reset-time strap capture
package strap_cfg_pkg;
  localparam int ratio_lsb = 0;
  localparam int ratio_msb = 2;
  localparam int lane_mode_bit = 3;
  localparam int upper_pin_bit = 4;
  localparam int port_size_lsb = 5;
  localparam int port_size_msb = 6;
  localparam int auto_ack_bit = 7;
  localparam logic [7:0] strap_reset_val = 8'h00;
  localparam logic [3:0] auto_ack_waits = 4'hf;
  localparam logic [1:0] ps_32 = 2'h0;
  localparam logic [1:0] ps_8 = 2'h1;
  localparam logic [1:0] width_32 = 2'h2;
  localparam logic [1:0] width_16 = 2'h1;
  localparam logic [1:0] width_8 = 2'h0;
  localparam logic [3:0] mult_none = 4'h0;
  localparam logic [3:0] mult_3 = 4'h3;
  localparam logic [3:0] mult_4 = 4'h4;
  localparam logic [3:0] mult_5 = 4'h5;
  localparam logic [3:0] mult_6 = 4'h6;
  localparam logic [2:0] code_3 = 3'h3;
  localparam logic [2:0] code_4 = 3'h4;
  localparam logic [2:0] code_5 = 3'h5;
  localparam logic [2:0] code_6 = 3'h6;
  localparam logic [31:0] word_reset_val = 32'h0000_0000;
  // arbitrary identity values, not those of any real part
  localparam logic [31:0] cfg_id_base = 32'h1234_5600;
  localparam logic [31:0] mem_id_val = 32'h0000_8421;
  localparam int rev_lsb = 4;
  localparam logic [3:0] core_rev_default = 4'h1;
  typedef enum logic [1:0] {st_reset, st_load, st_run} load_state_t;
endpackage : strap_cfg_pkg

// [strap_field_decode.sv]
// decodes captured straps into boot configuration
`timescale 1ns/1ps
`default_nettype none
module strap_field_decode (
  input wire logic [7:0] straps, // captured strap levels
  output logic [3:0] core_mult, // core multiplier, 0 when reserved
  output logic ratio_reserved, // ratio code is reserved
  output logic [1:0] port_width, // 2=32 bit, 1=16 bit, 0=8 bit
  output logic [3:0] ack_waits, // auto-ack wait states
  output logic ack_en // auto-ack on
);
  logic [2:0] code;
  logic [1:0] ps;
  assign code = straps[strap_cfg_pkg::ratio_msb:strap_cfg_pkg::ratio_lsb];
  assign ps = straps[strap_cfg_pkg::port_size_msb:
                     strap_cfg_pkg::port_size_lsb];
  always_comb begin
    unique case (code)
      strap_cfg_pkg::code_3: core_mult = strap_cfg_pkg::mult_3;
      strap_cfg_pkg::code_4: core_mult = strap_cfg_pkg::mult_4;
      strap_cfg_pkg::code_5: core_mult = strap_cfg_pkg::mult_5;
      strap_cfg_pkg::code_6: core_mult = strap_cfg_pkg::mult_6;
      default: core_mult = strap_cfg_pkg::mult_none;
    endcase
    ratio_reserved = (core_mult == strap_cfg_pkg::mult_none);
    if (ps == strap_cfg_pkg::ps_32) begin
      port_width = strap_cfg_pkg::width_32;
    end else if (ps == strap_cfg_pkg::ps_8) begin
      port_width = strap_cfg_pkg::width_8;
    end else begin
      port_width = strap_cfg_pkg::width_16;
    end
    ack_en = straps[strap_cfg_pkg::auto_ack_bit];
    ack_waits = ack_en ? strap_cfg_pkg::auto_ack_waits : 4'h0;
  end
endmodule : strap_field_decode
`default_nettype wire

// [reset_strap_config_capture.sv]
// reset-time strap capture and identification word load
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_capture (
  input wire logic core_clk, // bus clock input domain, 125 MHz
  input wire logic reset, // async reset, active high
  input wire logic reset_in_n, // board reset, low while held
  input wire logic [7:0] data_pins, // low data pins carrying straps
  input wire logic bus_clock_out_off, // 1 switches bus clock out off
  input wire logic [3:0] core_rev, // core revision for config word
  input wire logic other_cs_valid, // software validated other selects
  input wire logic boot_write, // boot access is a write
  input wire logic boot_access, // boot access in progress
  output logic [3:0] core_mult, // core clock multiplier
  output logic ratio_reserved, // reserved ratio code sampled
  output logic boot_auto_ack, // boot auto-acknowledge enabled
  output logic [3:0] boot_ack_waits, // wait states before auto-ack
  output logic [1:0] boot_port_size, // 2=32, 1=16, 0=8 bit
  output logic byte_lane_mode, // 1 lanes on reads and writes, 0 lanes on writes only
  output logic byte_lane_strobes_en, // lanes may assert this access
  output logic upper_pins_mode, // 1 address/control, 0 gpio inputs
  output logic boot_chip_select_only, // only boot select active
  output logic bus_clock_out_en, // gate enable for bus clock out
  output logic [31:0] config_info_register, // config word
  output logic [31:0] memory_info_register, // memory word
  output logic id_loaded // words loaded after release
);
  logic [7:0] straps_q, straps_d;
  logic rst_held_q, rst_held_d;
  logic valid_q, valid_d;
  logic [31:0] cfg_q, cfg_d, mem_q, mem_d;
  logic clk_en_q, clk_en_d;
  strap_cfg_pkg::load_state_t st_q, st_d;
  logic [1:0] pw;
  logic [3:0] waits;
  logic ack;

  // straps track the pins every edge while reset_in_n is low, so the
  // value kept is the one of the edge just before release
  always_comb begin
    straps_d = straps_q;
    rst_held_d = ~reset_in_n;
    if (!reset_in_n) begin
      straps_d = data_pins;
    end
  end

  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    mem_d = mem_q;
    unique case (st_q)
      strap_cfg_pkg::st_reset: begin
        if (reset_in_n && rst_held_q) begin
          st_d = strap_cfg_pkg::st_load;
        end
      end
      strap_cfg_pkg::st_load: begin
        cfg_d = strap_cfg_pkg::cfg_id_base
          | (32'(core_rev) << strap_cfg_pkg::rev_lsb);
        mem_d = strap_cfg_pkg::mem_id_val;
        st_d = strap_cfg_pkg::st_run;
      end
      strap_cfg_pkg::st_run: begin
        if (!reset_in_n) begin
          st_d = strap_cfg_pkg::st_reset;
        end
      end
    endcase
    if (!reset_in_n) begin
      st_d = strap_cfg_pkg::st_reset;
    end
  end

  always_comb begin
    valid_d = valid_q;
    if (!reset_in_n) begin
      valid_d = 1'b0;
    end else if (other_cs_valid) begin
      valid_d = 1'b1;
    end
    clk_en_d = ~bus_clock_out_off;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      straps_q <= strap_cfg_pkg::strap_reset_val;
      rst_held_q <= 1'b1;
      valid_q <= 1'b0;
      cfg_q <= strap_cfg_pkg::word_reset_val;
      mem_q <= strap_cfg_pkg::word_reset_val;
      clk_en_q <= 1'b1;
      st_q <= strap_cfg_pkg::st_reset;
    end else begin
      straps_q <= straps_d;
      rst_held_q <= rst_held_d;
      valid_q <= valid_d;
      cfg_q <= cfg_d;
      mem_q <= mem_d;
      clk_en_q <= clk_en_d;
      st_q <= st_d;
    end
  end

  strap_field_decode u_decode (
    .straps(straps_q),
    .core_mult(core_mult),
    .ratio_reserved(ratio_reserved),
    .port_width(pw),
    .ack_waits(waits),
    .ack_en(ack)
  );

  assign boot_auto_ack = ack;
  assign boot_ack_waits = waits;
  assign boot_port_size = pw;
  assign byte_lane_mode = straps_q[strap_cfg_pkg::lane_mode_bit];
  // lanes on writes only in mode 0, on all accesses in mode 1
  assign byte_lane_strobes_en = boot_access
    & (boot_write | byte_lane_mode);
  assign upper_pins_mode = straps_q[strap_cfg_pkg::upper_pin_bit];
  assign boot_chip_select_only = ~valid_q;
  // the bus clock out is the bus clock in gated, so same rate and
  // phase, and the same ratio to the core clock
  assign bus_clock_out_en = clk_en_q;
  assign config_info_register = cfg_q;
  assign memory_info_register = mem_q;
  assign id_loaded = (st_q == strap_cfg_pkg::st_run);
endmodule : reset_strap_config_capture
`default_nettype wire

// [strap_board_model.sv]
// board strap network and board reset source
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  input wire logic core_clk, // bus clock input
  input wire logic hold, // 1 holds board reset
  input wire logic [7:0] strap, // strap levels
  output var logic reset_in_n = 1'b0, // board reset, low held
  output var logic [7:0] data_pins = 8'h00 // low data pins
);
  // straps only while held; a live bus toggles afterwards
  always @(posedge core_clk) begin
    reset_in_n <= #1 ~hold;
    data_pins <= #1 hold ? strap : ~data_pins;
  end
endmodule : strap_board_model
`default_nettype wire

// [reset_strap_config_capture_sva.sv]
// checker for the strap capture ports
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_capture_sva (
  input wire logic core_clk, // clock
  input wire logic reset, // reset
  input wire logic reset_in_n, // board reset
  input wire logic [7:0] data_pins, // straps
  input wire logic bus_clock_out_off, // gate off
  input wire logic [3:0] core_rev, // revision
  input wire logic other_cs_valid, // validate
  input wire logic boot_write, // write
  input wire logic boot_access, // access
  input wire logic [3:0] core_mult, // multiplier
  input wire logic boot_auto_ack, // auto-ack
  input wire logic byte_lane_mode, // lane mode
  input wire logic byte_lane_strobes_en, // lanes
  input wire logic upper_pins_mode, // pins
  input wire logic boot_chip_select_only, // boot only
  input wire logic bus_clock_out_en, // clock out
  input wire logic [31:0] config_info_register, // config
  input wire logic [31:0] memory_info_register, // memory
  input wire logic id_loaded // loaded
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_strap_capture: assert property (
    reset_in_n && !$past(reset_in_n) |-> {boot_auto_ack, upper_pins_mode,
    byte_lane_mode} == {$past(data_pins[7]), $past(data_pins[4:3])})
    else $error("strap capture wrong");
  a_ratio_decode: assert property (
    reset_in_n && !$past(reset_in_n) |-> core_mult == (($past(data_pins[2:0])
    inside {3'h3, 3'h4, 3'h5, 3'h6}) ? {1'b0, $past(data_pins[2:0])} : 4'h0))
    else $error("ratio decode wrong");
  a_straps_static: assert property (
    reset_in_n && $past(reset_in_n) |-> $stable({core_mult, boot_auto_ack,
    byte_lane_mode, upper_pins_mode})) else $error("straps changed");
  a_lane_strobes: assert property (
    byte_lane_strobes_en == (boot_access && (boot_write || byte_lane_mode)))
    else $error("lane strobes wrong");
  a_words_load: assert property (
    $rose(reset_in_n) |-> ##2 id_loaded && memory_info_register ==
    strap_cfg_pkg::mem_id_val && config_info_register ==
    (strap_cfg_pkg::cfg_id_base | {24'h0, core_rev, 4'h0}))
    else $error("words not loaded");
  a_boot_only: assert property (
    !reset_in_n |=> boot_chip_select_only) else $error("boot select");
  a_cs_validate: assert property (
    reset_in_n && other_cs_valid |=> !boot_chip_select_only)
    else $error("validate lost");
  a_clock_gate: assert property (
    bus_clock_out_en == !$past(bus_clock_out_off)) else $error("clock gate");
endmodule : reset_strap_config_capture_sva
bind reset_strap_config_capture reset_strap_config_capture_sva u_sva (
  .core_clk(core_clk),
  .reset(reset),
  .reset_in_n(reset_in_n),
  .data_pins(data_pins),
  .bus_clock_out_off(bus_clock_out_off),
  .core_rev(core_rev),
  .other_cs_valid(other_cs_valid),
  .boot_write(boot_write),
  .boot_access(boot_access),
  .core_mult(core_mult),
  .boot_auto_ack(boot_auto_ack),
  .byte_lane_mode(byte_lane_mode),
  .byte_lane_strobes_en(byte_lane_strobes_en),
  .upper_pins_mode(upper_pins_mode),
  .boot_chip_select_only(boot_chip_select_only),
  .bus_clock_out_en(bus_clock_out_en),
  .config_info_register(config_info_register),
  .memory_info_register(memory_info_register),
  .id_loaded(id_loaded)
);
`default_nettype wire

// [tb.sv]
// testbench for reset strap capture
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hold = 1'b1;
  logic [7:0] strap = 8'h00;
  logic bus_clock_out_off = 1'b0;
  logic [3:0] core_rev = 4'h5;
  logic other_cs_valid = 1'b0;
  logic boot_write = 1'b0;
  logic boot_access = 1'b0;
  logic reset_in_n, ratio_reserved, boot_auto_ack, byte_lane_mode;
  logic byte_lane_strobes_en, upper_pins_mode, boot_chip_select_only;
  logic bus_clock_out_en, id_loaded;
  logic [7:0] data_pins;
  logic [3:0] core_mult, boot_ack_waits;
  logic [1:0] boot_port_size;
  logic [31:0] config_info_register, memory_info_register;
  int num_errors = 0;
  int total_checks = 0;
  always #4 core_clk = ~core_clk;
  strap_board_model u_strap_board_model (.*);
  reset_strap_config_capture u_reset_strap_config_capture (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // board reset with given straps, then release and judge the capture
  task automatic boot(input logic [7:0] s);
    logic [3:0] m;
    m = (s[2:0] inside {3'h3, 3'h4, 3'h5, 3'h6}) ? {1'b0, s[2:0]} : 4'h0;
    hold = 1'b1;
    strap = s;
    step(3);
    hold = 1'b0;
    step(4);
    check(core_mult, m);
    check(ratio_reserved, m == 4'h0);
    check(boot_port_size, s[6] ? 2'h1 : s[5] ? 2'h0 : 2'h2);
    check(boot_ack_waits, s[7] ? 4'hf : 4'h0);
    check({boot_auto_ack, upper_pins_mode, byte_lane_mode},
          {s[7], s[4:3]});
    check(memory_info_register, strap_cfg_pkg::mem_id_val);
    check(config_info_register, strap_cfg_pkg::cfg_id_base | 8'h50);
    check({id_loaded, boot_chip_select_only},
          {1'b1, ~other_cs_valid});
    for (int i = 0; i < 4; i++) begin
      {boot_access, boot_write} = i[1:0];
      step(1);
      check(byte_lane_strobes_en, i[1] & (i[0] | s[3]));
    end
    check(core_mult, m);
  endtask : boot
  // software validates the other selects around a boot
  task automatic validate_test;
    other_cs_valid = 1'b1;
    boot(8'h04);
    check(boot_chip_select_only, 1'b0);
  endtask : validate_test
  // switch the bus clock out off and on again
  task automatic clock_gate_test;
    bus_clock_out_off = 1'b1;
    step(2);
    check(bus_clock_out_en, 1'b0);
    bus_clock_out_off = 1'b0;
    step(2);
    check(bus_clock_out_en, 1'b1);
  endtask : clock_gate_test
  // board reset, core reset while the board reset is held, then a fresh boot
  task automatic reset_test;
    hold = 1'b1;
    step(3);
    check(boot_chip_select_only, 1'b1);
    reset = 1'b1;
    step(1);
    check({id_loaded, core_mult}, 5'h00);
    reset = 1'b0;
    step(3);
    boot(8'h84);
  endtask : reset_test
  initial begin
    step(12);
    reset = 1'b0;
    step(2);
    for (int i = 0; i < 8; i++) boot({i[2:0], i[1:0], i[2:0]});
    validate_test();
    clock_gate_test();
    reset_test();
    final_report();
  end
endmodule : tb
`default_nettype wire
